// ===== include/ectc_pkg.sv
// constants of the encoder timer capture/compare block
// assumes a 32-bit apb slave with word aligned registers
package ectc_pkg;

  // ------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------
  localparam logic [31:0] ADR_NFS0 = 32'hfffff598;
  localparam logic [31:0] ADR_NFS1 = 32'hfffff5b8;
  localparam logic [31:0] ADR_CTRL = 32'hfffff5c0;
  localparam logic [31:0] ADR_CMPA = 32'hfffff5c4;
  localparam logic [31:0] ADR_CMPB = 32'hfffff5c8;
  localparam logic [31:0] ADR_CCA  = 32'hfffff5cc;
  localparam logic [31:0] ADR_CCB  = 32'hfffff5d0;
  localparam logic [31:0] ADR_STAT = 32'hfffff5d4;

  // ------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------
  localparam int CT_EN    = 0;
  localparam int CT_UDM   = 1;
  localparam int CT_VAR   = 2;
  localparam int CT_CCAM  = 3;
  localparam int CT_CCBM  = 4;
  localparam int CT_BSRC  = 5;
  localparam int CT_CLRU  = 6;
  localparam int CT_ESA   = 7;
  localparam int CT_ESB   = 9;
  localparam int CT_TFN   = 11;
  localparam int CT_W     = 12;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0]  RST_NFS  = 8'h00;
  localparam logic [11:0] RST_CTRL = 12'h000;
  localparam logic [15:0] RST_CMP  = 16'h0000;

  // ------------------------------------------------------------
  // filter and edge codes
  // ------------------------------------------------------------
  localparam int FILT_SAMPLES = 5;
  localparam logic [5:0] DIV_32 = 6'h20;
  localparam logic [5:0] DIV_16 = 6'h10;
  localparam logic [5:0] DIV_8  = 6'h08;
  localparam logic [5:0] DIV_4  = 6'h04;
  localparam logic [1:0] EDG_FALL = 2'h0;
  localparam logic [1:0] EDG_RISE = 2'h1;
  localparam logic [1:0] EDG_BOTH = 2'h3;

endpackage

// ===== rtl/ectc_tick_div.sv
// sampling tick divider for the noise filters
// assumes sel is held stable while enable is high
`timescale 1ns/1ps
module ectc_tick_div
  import ectc_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // control
  input  wire logic       enable,
  input  wire logic [1:0] sel,
  // tick out
  output logic            tick_ff
);

  logic [5:0] cnt_ff;
  logic [5:0] period;

  // ------------------------------------------------------------
  // period select
  // ------------------------------------------------------------
  always_comb begin
    unique case (sel)
      2'h0: period = DIV_32;
      2'h1: period = DIV_16;
      2'h2: period = DIV_8;
      2'h3: period = DIV_4;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset || !enable) begin
      cnt_ff  <= 6'h00;
      tick_ff <= 1'b0;
    end else if (cnt_ff == period - 6'h01) begin
      cnt_ff  <= 6'h00;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff  <= cnt_ff + 6'h01;
      tick_ff <= 1'b0;
    end
  end

  chk_tick_spacing: assert property (@(posedge clk_sys) disable iff (reset)
    tick_ff |=> !tick_ff [*3])
    else $error("filter ticks closer than four cycles");

endmodule

// ===== rtl/ectc_noise_filter.sv
// digital noise filter for one timer input pin
// assumes pin is asynchronous; tick comes from ectc_tick_div
`timescale 1ns/1ps
module ectc_noise_filter
  import ectc_pkg::*;
#(
  parameter int SAMPLES = FILT_SAMPLES
)(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // control
  input  wire logic tick,
  input  wire logic enable,
  input  wire logic timer_fn,
  // pin in, level out
  input  wire logic pin,
  output logic      level_ff
);

  logic               sync1_ff;
  logic               sync2_ff;
  logic [SAMPLES-1:0] samp_ff;
  logic               uniform;

  assign uniform = &samp_ff || ~|samp_ff;

  // ------------------------------------------------------------
  // synchroniser and sample history
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= pin;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      samp_ff <= '0;
    end else if (tick && enable) begin
      samp_ff <= {samp_ff[SAMPLES-2:0], sync2_ff};
    end
  end

  // ------------------------------------------------------------
  // accepted level
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      level_ff <= 1'b0;
    end else if (!timer_fn) begin
      level_ff <= sync2_ff;
    end else if (&samp_ff) begin
      level_ff <= 1'b1;
    end else if (~|samp_ff) begin
      level_ff <= 1'b0;
    end
  end

  chk_filter_level: assert property (@(posedge clk_sys) disable iff (reset)
    (timer_fn && $past(timer_fn) && $changed(level_ff)) |->
    $past(uniform))
    else $error("level accepted without five equal samples");

endmodule

// ===== rtl/ectc_top.sv
// compare and capture/compare channels with pin noise filters
// assumes counter value and direction come from same-clock logic
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module ectc_top
  import ectc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // counter side
  input  wire logic [15:0] count_value,
  input  wire logic        count_down,
  output logic             count_enable_bit,
  output logic             updown_mode_bit,
  output logic             updown_variant_bit,
  // pins
  input  wire logic        count_input_pin,
  input  wire logic        direction_input_pin,
  input  wire logic        clear_input_pin,
  // filtered levels
  output logic             count_in_filt,
  output logic             dir_in_filt,
  output logic             clr_in_filt,
  // interrupt pulses
  output logic             compare_a_irq,
  output logic             compare_b_irq,
  output logic             capcomp_a_irq,
  output logic             capcomp_b_irq
);

  logic [7:0]      nfs0_ff;
  logic [7:0]      nfs1_ff;
  logic [CT_W-1:0] ctrl_ff;
  logic [15:0]     cmpa_ff;
  logic [15:0]     cmpb_ff;
  logic [15:0]     cca_ff;
  logic [15:0]     ccb_ff;
  logic [15:0]     cnt_ff;
  logic            down_ff;
  logic [31:0]     nxt_rdata;
  logic            nxt_err;
  logic            wr_en;
  logic            tick;
  logic [2:0]      pins;
  logic [2:0]      filt;
  logic [2:0]      prev_ff;
  logic [3:0]      mprev_ff;
  logic [3:0]      match;
  logic            en;
  logic            mode_b;
  logic            edge_a;
  logic            edge_b;
  logic            cap_a_stb;
  logic            cap_b_stb;

  assign en     = ctrl_ff[CT_EN];
  assign mode_b = ctrl_ff[CT_UDM] && ctrl_ff[CT_VAR];
  assign pins   = {clear_input_pin, direction_input_pin,
                   count_input_pin};
  assign wr_en  = psel && penable && pready && pwrite;

  // ------------------------------------------------------------
  // apb answer: one wait state, registered data
  // ------------------------------------------------------------
  always_comb begin
    nxt_err   = 1'b0;
    nxt_rdata = 32'h0000_0000;
    unique case (paddr)
      ADR_NFS0: nxt_rdata = {24'h000000, nfs0_ff};
      ADR_NFS1: nxt_rdata = {24'h000000, nfs1_ff};
      ADR_CTRL: nxt_rdata = {20'h00000, ctrl_ff};
      ADR_CMPA: nxt_rdata = {16'h0000, cmpa_ff};
      ADR_CMPB: nxt_rdata = {16'h0000, cmpb_ff};
      ADR_CCA:  nxt_rdata = {16'h0000, cca_ff};
      ADR_CCB:  nxt_rdata = {16'h0000, ccb_ff};
      ADR_STAT: nxt_rdata = {27'h0000000, down_ff, filt, en};
      default:  nxt_err   = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= nxt_err;
      prdata  <= pwrite ? 32'h0000_0000 : nxt_rdata;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      nfs0_ff <= RST_NFS;
      nfs1_ff <= RST_NFS;
      ctrl_ff <= RST_CTRL;
      cmpa_ff <= RST_CMP;
      cmpb_ff <= RST_CMP;
    end else if (wr_en) begin
      // NFS registers keep bits 1:0 only, others read as zero; software keeps them still while running
      unique case (paddr)
        ADR_NFS0: nfs0_ff <= {6'h00, pwdata[1:0]};
        ADR_NFS1: nfs1_ff <= {6'h00, pwdata[1:0]};
        ADR_CTRL: ctrl_ff <= pwdata[CT_W-1:0];
        ADR_CMPA: cmpa_ff <= pwdata[15:0];
        ADR_CMPB: cmpb_ff <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  assign count_enable_bit   = ctrl_ff[CT_EN];
  assign updown_mode_bit    = ctrl_ff[CT_UDM];
  assign updown_variant_bit = ctrl_ff[CT_VAR];

  // ------------------------------------------------------------
  // noise filters
  // ------------------------------------------------------------
  ectc_tick_div u_div (
    .clk_sys (clk_sys),
    .reset   (reset),
    .enable  (en),
    .sel     (nfs0_ff[1:0]),
    .tick_ff (tick)
  );

  for (genvar i = 0; i < 3; i++) begin : g_filt
    ectc_noise_filter u_filt (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .tick     (tick),
      .enable   (en),
      .timer_fn (ctrl_ff[CT_TFN]),
      .pin      (pins[i]),
      .level_ff (filt[i])
    );
  end

  assign count_in_filt = filt[0];
  assign dir_in_filt   = filt[1];
  assign clr_in_filt   = filt[2];

  // ------------------------------------------------------------
  // capture triggers
  // ------------------------------------------------------------
  function automatic logic edge_hit(input logic [1:0] code,
                                    input logic cur, input logic old);
    logic rise;
    logic fall;
    rise = cur && !old;
    fall = !cur && old;
    unique case (code)
      EDG_FALL: edge_hit = fall;
      EDG_RISE: edge_hit = rise;
      EDG_BOTH: edge_hit = rise || fall;
      default:  edge_hit = 1'b0;
    endcase
  endfunction

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prev_ff <= 3'h0;
    end else begin
      prev_ff <= filt;
    end
  end

  always_comb begin
    edge_a = edge_hit(ctrl_ff[CT_ESA+:2], filt[1], prev_ff[1]);
    if (ctrl_ff[CT_BSRC]) begin
      edge_b = edge_hit(ctrl_ff[CT_ESB+:2], filt[1], prev_ff[1]) &&
               !ctrl_ff[CT_UDM];
    end else begin
      edge_b = edge_hit(ctrl_ff[CT_ESB+:2], filt[2], prev_ff[2]) &&
               !(ctrl_ff[CT_UDM] && !ctrl_ff[CT_VAR] &&
                 ctrl_ff[CT_CLRU]);
    end
  end

  assign cap_a_stb = en && !ctrl_ff[CT_CCAM] && !ctrl_ff[CT_UDM] &&
                     edge_a;
  assign cap_b_stb = en && !ctrl_ff[CT_CCBM] && edge_b;

  // ------------------------------------------------------------
  // counter sample and compare matches
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_ff  <= 16'h0000;
      down_ff <= 1'b0;
    end else begin
      cnt_ff  <= count_value;
      down_ff <= count_down;
    end
  end

  assign match[0] = cnt_ff == cmpa_ff;
  assign match[1] = cnt_ff == cmpb_ff;
  assign match[2] = ctrl_ff[CT_CCAM] && cnt_ff == cca_ff;
  assign match[3] = ctrl_ff[CT_CCBM] && cnt_ff == ccb_ff;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mprev_ff <= 4'h0;
    end else begin
      mprev_ff <= match;
    end
  end

  // ------------------------------------------------------------
  // capture/compare registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cca_ff <= RST_CMP;
    end else if (cap_a_stb) begin
      cca_ff <= cnt_ff;
    end else if (wr_en && paddr == ADR_CCA) begin
      cca_ff <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ccb_ff <= RST_CMP;
    end else if (cap_b_stb) begin
      ccb_ff <= cnt_ff;
    end else if (wr_en && paddr == ADR_CCB) begin
      ccb_ff <= pwdata[15:0];
    end
  end

  // ------------------------------------------------------------
  // interrupt pulses
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      compare_a_irq <= 1'b0;
      compare_b_irq <= 1'b0;
      capcomp_a_irq <= 1'b0;
      capcomp_b_irq <= 1'b0;
    end else begin
      compare_a_irq <= en && match[0] && !mprev_ff[0] &&
                       (!mode_b || !down_ff);
      compare_b_irq <= en && match[1] && !mprev_ff[1] &&
                       (!mode_b || down_ff);
      capcomp_a_irq <= cap_a_stb ||
                       (en && match[2] && !mprev_ff[2]);
      capcomp_b_irq <= cap_b_stb ||
                       (en && match[3] && !mprev_ff[3]);
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_cap_a;
    cap_a_stb;
  endsequence

  sequence s_new_match_a;
    en && match[0] && !mprev_ff[0];
  endsequence

  chk_cmpa_timer_irq: assert property (
    (s_new_match_a and !mode_b) |=> compare_a_irq)
    else $error("compare a match without interrupt");

  chk_cmpa_modeb_up: assert property (
    compare_a_irq |-> !$past(mode_b) || !$past(down_ff))
    else $error("compare a interrupt while counting down");

  chk_cmpb_modeb_dn: assert property (
    (compare_b_irq && $past(mode_b)) |-> $past(down_ff))
    else $error("compare b interrupt while counting up");

  chk_cap_off_stop: assert property (
    !en |-> !cap_a_stb && !cap_b_stb)
    else $error("capture while counter stopped");

  chk_cap_a_value: assert property (
    s_cap_a |=> cca_ff == $past(cnt_ff) && capcomp_a_irq)
    else $error("capcomp a did not latch the count");

  chk_cap_b_value: assert property (
    cap_b_stb |=> ccb_ff == $past(cnt_ff) && capcomp_b_irq)
    else $error("capcomp b did not latch the count");

  chk_cap_a_hold: assert property (
    (!ctrl_ff[CT_CCAM] && !cap_a_stb && !wr_en) |=> $stable(cca_ff))
    else $error("capcomp a changed without capture");

  chk_udc_no_dircap: assert property (
    ctrl_ff[CT_UDM] |-> !cap_a_stb)
    else $error("direction capture in up/down mode");

  chk_edge_bad_code: assert property (
    ctrl_ff[CT_ESA+:2] == 2'h2 |-> !cap_a_stb)
    else $error("capture on prohibited edge code");

  chk_match_pulse: assert property (
    compare_a_irq |=> !compare_a_irq)
    else $error("compare a interrupt longer than a cycle");

endmodule

// ===== testbench/ectc_pin_model.sv
// pulse source standing on the three timer pins
// assumes the bench calls pulse() from its main sequence
`timescale 1ns/1ps
module ectc_pin_model (
  // clock
  input  wire logic clk_sys,
  // pins
  output logic      count_input_pin,
  output logic      direction_input_pin,
  output logic      clear_input_pin
);
  logic [2:0] lvl_ff = 3'h0;

  assign count_input_pin     = lvl_ff[0];
  assign direction_input_pin = lvl_ff[1];
  assign clear_input_pin     = lvl_ff[2];

  // high pulse of whole clock cycles, length as asked
  task automatic pulse(input int p, input int len);
    @(posedge clk_sys);
    lvl_ff[p] <= 1'b1;
    repeat (len) @(posedge clk_sys);
    lvl_ff[p] <= 1'b0;
  endtask
endmodule

// ===== testbench/tb.sv
// self-checking bench for the capture/compare block
// assumes ectc_pin_model drives the pins, bench drives the counter
`timescale 1ns/1ps
module tb
  import ectc_pkg::*;
;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [31:0] EN  = 32'h001;
  localparam logic [31:0] UD  = 32'h002;
  localparam logic [31:0] VB  = 32'h004;
  localparam logic [31:0] CAM = 32'h008;
  localparam logic [31:0] CBM = 32'h010;
  localparam logic [31:0] BSR = 32'h020;
  localparam logic [31:0] CLU = 32'h040;
  localparam logic [31:0] TF  = 32'h800;
  logic        clk_sys     = 1'b0;
  logic        reset       = 1'b1;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [31:0] paddr       = 32'h0;
  logic [31:0] pwdata      = 32'h0;
  logic [15:0] count_value = 16'hffff;
  logic        count_down  = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        en_bit;
  logic        ud_bit;
  logic        vb_bit;
  logic [6:0]  mon;
  logic        cin;
  logic        din;
  logic        rin;
  logic        cf;
  logic        df;
  logic        rf;
  logic [3:0]  irq;
  int          cnt[7];
  int          base[7];
  int          err_count = 0;
  int          checks    = 0;
  int          settle    = 50;

  always #5 clk_sys = ~clk_sys;

  ectc_top ectc_top_inst (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_value(count_value),
    .count_down(count_down), .count_enable_bit(en_bit),
    .updown_mode_bit(ud_bit), .updown_variant_bit(vb_bit),
    .count_input_pin(cin), .direction_input_pin(din),
    .clear_input_pin(rin), .count_in_filt(cf), .dir_in_filt(df),
    .clr_in_filt(rf), .compare_a_irq(irq[0]), .compare_b_irq(irq[1]),
    .capcomp_a_irq(irq[2]), .capcomp_b_irq(irq[3])
  );

  ectc_pin_model ectc_pin_model_inst (
    .clk_sys(clk_sys), .count_input_pin(cin),
    .direction_input_pin(din), .clear_input_pin(rin)
  );

  // high cycles of each pulse output and filtered level
  assign mon = {rf, cf, df, irq};

  always @(posedge clk_sys) begin
    for (int k = 0; k < 7; k++) begin
      if (mon[k] === 1'b1) begin
        cnt[k]++;
      end
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] got(input int k);
    return 32'(cnt[k] - base[k]);
  endfunction

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic apb(input logic [31:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b1, d, r, e);
  endtask

  task automatic rd_chk(input string nm, input logic [31:0] a,
                        input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b0, 32'h0, r, e);
    check(nm, x, r);
  endtask

  // counter stopped while fields change, then started if v sets EN
  task automatic set_ctrl(input logic [31:0] v);
    wr(ADR_CTRL, v & ~EN);
    wr(ADR_CTRL, v);
    rd_chk("ctrl", ADR_CTRL, v);
    check("ctrl_bits", 32'({v[CT_VAR], v[CT_UDM], v[CT_EN]}),
          32'({vb_bit, ud_bit, en_bit}));
  endtask

  task automatic cmp_step(input logic [15:0] v, input logic d,
                          input logic [3:0] x);
    base = cnt;
    @(posedge clk_sys);
    count_value <= v;
    count_down <= d;
    repeat (10) @(posedge clk_sys);
    count_value <= 16'hffff;
    repeat (4) @(posedge clk_sys);
    for (int k = 0; k < 4; k++) begin
      check($sformatf("irq%0d", k), 32'(x[k]), got(k));
    end
  endtask

  task automatic pin_step(input int p, input int len);
    base = cnt;
    ectc_pin_model_inst.pulse(p, len);
    repeat (settle) @(posedge clk_sys);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic        e;
    int          n;
    int          ea[4];
    ea = '{1, 1, 0, 2};
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    rd_chk("nfs0", ADR_NFS0, 32'h0);
    rd_chk("nfs1", ADR_NFS1, 32'h0);
    rd_chk("ctrl", ADR_CTRL, 32'h0);
    rd_chk("cmpa", ADR_CMPA, 32'h0);
    rd_chk("cmpb", ADR_CMPB, 32'h0);
    rd_chk("cca", ADR_CCA, 32'h0);
    rd_chk("ccb", ADR_CCB, 32'h0);
    apb(32'hfffff5f0, 1'b0, 32'h0, r, e);
    check("slverr", 32'h1, 32'(e));
    wr(ADR_NFS1, 32'hff);
    rd_chk("nfs1", ADR_NFS1, 32'h3);
    wr(ADR_CMPA, 32'h1234);
    wr(ADR_CMPB, 32'h4321);
    rd_chk("cmpa", ADR_CMPA, 32'h1234);
    rd_chk("cmpb", ADR_CMPB, 32'h4321);
    set_ctrl(EN | TF);
    cmp_step(16'h1234, 1'b0, 4'b0001);
    cmp_step(16'h4321, 1'b1, 4'b0010);
    set_ctrl(EN | UD | TF);
    cmp_step(16'h1234, 1'b1, 4'b0001);
    set_ctrl(EN | UD | VB | TF);
    cmp_step(16'h1234, 1'b0, 4'b0001);
    cmp_step(16'h1234, 1'b1, 4'b0000);
    cmp_step(16'h4321, 1'b1, 4'b0010);
    cmp_step(16'h4321, 1'b0, 4'b0000);
    set_ctrl(CAM | CBM);
    wr(ADR_CCA, 32'h0aaa);
    wr(ADR_CCB, 32'h0bbb);
    set_ctrl(EN | CAM | CBM | TF);
    cmp_step(16'h0aaa, 1'b0, 4'b0100);
    cmp_step(16'h0bbb, 1'b0, 4'b1000);
    wr(ADR_NFS0, 32'h3);
    for (int c = 0; c < 4; c++) begin
      set_ctrl(EN | TF | (32'(c) << CT_ESA));
      count_value <= 16'h0a50 + 16'(c);
      pin_step(1, 40);
      check("cap_a_irq", 32'(ea[c]), got(2));
      if (c != 2) begin
        rd_chk("cap_a", ADR_CCA, 32'h0a50 + 32'(c));
      end
    end
    set_ctrl(TF | (32'h3 << CT_ESA));
    pin_step(1, 40);
    check("stopped_irq", 32'h0, got(2));
    check("stopped_filt", 32'h0, got(4));
    set_ctrl(EN | TF | (32'h3 << CT_ESB));
    count_value <= 16'h0b01;
    pin_step(2, 40);
    check("cap_b_irq", 32'h2, got(3));
    rd_chk("cap_b", ADR_CCB, 32'h0b01);
    set_ctrl(EN | TF | BSR | (32'h3 << CT_ESB));
    count_value <= 16'h0b02;
    pin_step(1, 40);
    check("cap_b_dir", 32'h2, got(3));
    check("cap_a_fall", 32'h1, got(2));
    rd_chk("cap_b", ADR_CCB, 32'h0b02);
    set_ctrl(EN | UD | TF | BSR | (32'h3 << CT_ESA) | (32'h3 << CT_ESB));
    pin_step(1, 40);
    check("ud_cap_a", 32'h0, got(2));
    check("ud_cap_b", 32'h0, got(3));
    set_ctrl(EN | UD | CLU | TF | (32'h3 << CT_ESB));
    pin_step(2, 40);
    check("clr_cap_b", 32'h0, got(3));
    for (int c = 0; c < 4; c++) begin
      n = 32 >> c;
      settle = 8 * n + 10;
      wr(ADR_NFS0, 32'(c));
      set_ctrl(EN | TF | (32'h3 << CT_ESA));
      pin_step(1, 3 * n);
      check("short", 32'h0, got(2));
      pin_step(1, 7 * n);
      check("long", 32'h2, got(2));
    end
    settle = 50;
    set_ctrl(EN | (32'h3 << CT_ESA));
    pin_step(0, 3);
    check("port_count", 32'h3, got(5));
    pin_step(2, 3);
    check("port_clear", 32'h3, got(6));
    report_and_stop();
  end
endmodule
